// ---- pkg/hph_pkg.sv ----
// Package with the register map, field positions, reset values and timing of the loop history block.
package hph_pkg;
    // Register byte addresses.
    localparam logic [15:0] ADDR_FREE_TW0  = 16'h0400;
    localparam logic [15:0] ADDR_FREE_TW1  = 16'h0401;
    localparam logic [15:0] ADDR_FREE_TW2  = 16'h0402;
    localparam logic [15:0] ADDR_FREE_TW3  = 16'h0403;
    localparam logic [15:0] ADDR_HIST_LO   = 16'h040B;
    localparam logic [15:0] ADDR_HIST_HI   = 16'h040C;
    localparam logic [15:0] ADDR_HIST_CTRL = 16'h040D;
    localparam logic [15:0] ADDR_PHOFS0    = 16'h040E;
    localparam logic [15:0] ADDR_PHOFS1    = 16'h040F;
    localparam logic [15:0] ADDR_PHOFS2    = 16'h0410;
    localparam logic [15:0] ADDR_PHOFS3    = 16'h0411;
    localparam logic [15:0] ADDR_STEP_LO   = 16'h0412;
    localparam logic [15:0] ADDR_STEP_HI   = 16'h0413;
    localparam logic [15:0] ADDR_SLEW_LO   = 16'h0414;
    localparam logic [15:0] ADDR_SLEW_HI   = 16'h0415;
    localparam logic [15:0] ADDR_OP_CTRL   = 16'h0A24;
    // Reset values and field layout.
    localparam logic [15:0] HIST_TMR_RST   = 16'h000A;
    localparam int          FALLBACK_BIT   = 4;
    localparam int          PERSIST_BIT    = 3;
    localparam int          INCR_W         = 3;
    localparam int          TOP_BYTE_W     = 6;
    localparam int          OP_INC_BIT     = 0;
    localparam int          OP_DEC_BIT     = 1;
    localparam int          OP_RST_BIT     = 2;
    localparam int          TW_W           = 30;
    localparam int          PH_W           = 30;
    localparam int          SUM_W          = TW_W + 16;
    // Timing: the history timer counts in milliseconds of the 25 MHz system clock.
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          MS_NS          = 1000000;
    localparam int          MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
    // One slew unit of 1 us/s allows 1000 ps of movement per millisecond.
    localparam int          SLEW_PS_PER_MS = 1000;
    // History phases: first interval allows early updates, steady does not.
    typedef enum logic [0:0] {
        HPH_FIRST  = 1'b0,
        HPH_STEADY = 1'b1
    } hph_state_t;
endpackage

// ---- pkg/hph_core_if.sv ----
// Interface carrying configuration and results between the register file and its engines.
interface hph_core_if;
    import hph_pkg::*;
    logic                    ms_tick;
    logic [15:0]             period;
    logic [INCR_W-1:0]       incr;
    logic                    persist;
    logic                    ref_switch;
    logic                    holdover;
    logic [TW_W-1:0]         loop_tw;
    logic [TW_W-1:0]         avg_tw;
    logic                    hist_valid;
    logic signed [PH_W-1:0]  fixed_ofs;
    logic [15:0]             step;
    logic [15:0]             slew;
    logic                    locked;
    logic                    op_inc;
    logic                    op_dec;
    logic                    op_rst;
    logic signed [PH_W-1:0]  incr_ofs;
    logic signed [PH_W-1:0]  target;
    logic signed [PH_W-1:0]  applied;
    modport ctrl (output ms_tick, period, incr, persist, ref_switch, holdover, loop_tw,
                  fixed_ofs, step, slew, locked, op_inc, op_dec, op_rst,
                  input avg_tw, hist_valid, incr_ofs, target, applied);
    modport hist (input ms_tick, period, incr, persist, ref_switch, holdover, loop_tw,
                  output avg_tw, hist_valid);
    modport offs (input ms_tick, fixed_ofs, step, slew, locked, op_inc, op_dec, op_rst,
                  output incr_ofs, target, applied);
endinterface

// ---- src/hph_history.sv ----
// Tuning word history averaging with early updates in the first interval.
module hph_history
    import hph_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    hph_core_if.hist  h
);
    logic [15:0]      ms_reg,    ms_next;
    logic [SUM_W-1:0] sum_reg,   sum_next;
    logic [15:0]      n_reg,     n_next;
    logic [TW_W-1:0]  avg_reg,   avg_next;
    logic             valid_reg, valid_next;
    hph_state_t       state_reg, state_next;
    logic [15:0]      ms_inc;
    logic [15:0]      n_inc;
    logic [SUM_W-1:0] sum_inc;

    // True when the elapsed count hits 1/2 .. 1/2^n of the period, down to 1/2^8 for n = 7.
    function automatic logic is_early(input logic [15:0] cnt, input logic [15:0] per,
                                      input logic [INCR_W-1:0] n);
        logic hit;
        int   deepest;
        hit     = 1'b0;
        // The top code reaches 1/256, one halving more than its own value would give.
        deepest = (n == '1) ? int'(n) + 1 : int'(n);
        for (int k = 1; k <= (1 << INCR_W); k++) begin
            if (k <= deepest && (per >> k) != 16'h0000 && cnt == (per >> k)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Accumulate one sample per millisecond outside holdover.
    always_comb begin
        ms_inc     = ms_reg + 16'h0001;
        n_inc      = n_reg + 16'h0001;
        sum_inc    = sum_reg + SUM_W'(h.loop_tw);
        ms_next    = ms_reg;
        sum_next   = sum_reg;
        n_next     = n_reg;
        avg_next   = avg_reg;
        valid_next = valid_reg;
        state_next = state_reg;
        if (h.ref_switch && !h.persist) begin
            ms_next    = 16'h0000;
            sum_next   = '0;
            n_next     = 16'h0000;
            valid_next = 1'b0;
            state_next = HPH_FIRST;
        end else if (h.ms_tick && !h.holdover) begin
            ms_next  = ms_inc;
            sum_next = sum_inc;
            n_next   = n_inc;
            if (ms_inc >= h.period) begin
                avg_next   = TW_W'(sum_inc / SUM_W'(n_inc));
                valid_next = 1'b1;
                ms_next    = 16'h0000;
                sum_next   = '0;
                n_next     = 16'h0000;
                state_next = HPH_STEADY;
            end else if (state_reg == HPH_FIRST && is_early(ms_inc, h.period, h.incr)) begin
                avg_next   = TW_W'(sum_inc / SUM_W'(n_inc));
                valid_next = 1'b1;
            end
        end
    end

    // History registers; the last average is kept until a newer one lands.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_reg    <= 16'h0000;
            sum_reg   <= '0;
            n_reg     <= 16'h0000;
            avg_reg   <= '0;
            valid_reg <= 1'b0;
            state_reg <= HPH_FIRST;
        end else begin
            ms_reg    <= ms_next;
            sum_reg   <= sum_next;
            n_reg     <= n_next;
            avg_reg   <= avg_next;
            valid_reg <= valid_next;
            state_reg <= state_next;
        end
    end

    assign h.avg_tw     = avg_reg;
    assign h.hist_valid = valid_reg;
endmodule

// ---- src/hph_offset.sv ----
// Closed-loop phase offset: incremental steps and slew-limited application.
module hph_offset
    import hph_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    hph_core_if.offs  o
);
    logic signed [PH_W-1:0] incr_reg,    incr_next;
    logic signed [PH_W-1:0] applied_reg, applied_next;
    logic signed [PH_W-1:0] target;
    logic signed [31:0]     diff;
    logic signed [31:0]     lim;

    // Absolute value of a signed difference.
    function automatic logic signed [31:0] mag(input logic signed [31:0] v);
        return (v < 0) ? -v : v;
    endfunction

    assign target = o.fixed_ofs + incr_reg;

    // Steps apply only while locked; reset of the offset wins over a step.
    always_comb begin
        incr_next    = incr_reg;
        applied_next = applied_reg;
        diff         = 32'(target) - 32'(applied_reg);
        lim          = 32'(o.slew) * SLEW_PS_PER_MS;
        if (o.op_rst) begin
            incr_next = '0;
        end else if (o.locked && o.op_inc && !o.op_dec) begin
            incr_next = incr_reg + PH_W'(o.step);
        end else if (o.locked && o.op_dec && !o.op_inc) begin
            incr_next = incr_reg - PH_W'(o.step);
        end
        if (o.slew == 16'h0000) begin
            applied_next = target;
        end else if (o.ms_tick) begin
            if (mag(diff) <= lim) begin
                applied_next = target;
            end else if (diff > 0) begin
                applied_next = applied_reg + PH_W'(lim);
            end else begin
                applied_next = applied_reg - PH_W'(lim);
            end
        end
    end

    // Offset registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            incr_reg    <= '0;
            applied_reg <= '0;
        end else begin
            incr_reg    <= incr_next;
            applied_reg <= applied_next;
        end
    end

    assign o.incr_ofs = incr_reg;
    assign o.target   = target;
    assign o.applied  = applied_reg;
endmodule

// ---- src/hph_top.sv ----
// Register bank and holdover word selection for the first digital loop's history and offset.
// Operation
// - Average tuning word over programmable millisecond period.
// - Without history, fall back to free-run or last.
// - Reference switch clears history unless persistence set.
// - Early updates only during the first interval.
// - Value n adds updates at 1/2..1/2^n (1/2..1/2^8 for n = 7).
// - Signed 30-bit phase offset over four bytes.
// - Hold 16-bit offset step size in picoseconds.
// - Separate control bits step or reset offset.
// - Multi-byte fields are little-endian by address.
// - Free-run tuning word is 30 bits, default zero.
// - Phase slewing limited by rate; zero disables.
module hph_top
    import hph_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)
(
    input  wire logic                REF_CLK,
    input  wire logic                RESET_N,
    input  wire logic [15:0]         ADDR,
    input  wire logic [7:0]          WR_DATA,
    input  wire logic                WR_STB,
    input  wire logic                RD_STB,
    output logic      [7:0]          RD_DATA,
    input  wire logic [TW_W-1:0]     LOOP_TW,
    input  wire logic                LOOP_LOCKED,
    input  wire logic                REF_SWITCH,
    input  wire logic                IN_HOLDOVER,
    output logic      [TW_W-1:0]     HOLD_TW,
    output logic                     HISTORY_VALID,
    output logic signed [PH_W-1:0]   PHASE_OFFSET
);
    import hph_pkg::*;

    // Loop inputs come from logic on REF_CLK, so they are used without synchronisers.
    hph_core_if c ();

    logic [TW_W-1:0]       free_tw_reg,  free_tw_next;
    logic [15:0]           tmr_reg,      tmr_next;
    logic [7:0]            ctrl_reg,     ctrl_next;
    logic [PH_W-1:0]       phofs_reg,    phofs_next;
    logic [15:0]           step_reg,     step_next;
    logic [15:0]           slew_reg,     slew_next;
    logic [2:0]            op_reg,       op_next;
    logic [7:0]            rd_reg,       rd_next;
    logic [15:0]           pre_reg,      pre_next;
    logic                  tick_reg,     tick_next;
    logic [TW_W-1:0]       last_tw_reg,  last_tw_next;
    logic [TW_W-1:0]       hold_reg,     hold_next;
    logic                  valid_reg,    valid_next;
    logic signed [PH_W-1:0] ofs_reg,     ofs_next;

    // True when a strobe addresses the given byte.
    function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
        return a == reg_addr;
    endfunction

    // Register writes; byte 0 of each field sits at the lowest address.
    always_comb begin
        free_tw_next = free_tw_reg;
        tmr_next     = tmr_reg;
        ctrl_next    = ctrl_reg;
        phofs_next   = phofs_reg;
        step_next    = step_reg;
        slew_next    = slew_reg;
        op_next      = 3'h0;
        if (WR_STB) begin
            if (hit(ADDR, ADDR_FREE_TW0)) free_tw_next[7:0]   = WR_DATA;
            if (hit(ADDR, ADDR_FREE_TW1)) free_tw_next[15:8]  = WR_DATA;
            if (hit(ADDR, ADDR_FREE_TW2)) free_tw_next[23:16] = WR_DATA;
            if (hit(ADDR, ADDR_FREE_TW3)) free_tw_next[29:24] = WR_DATA[TOP_BYTE_W-1:0];
            if (hit(ADDR, ADDR_HIST_LO))  tmr_next[7:0]       = WR_DATA;
            if (hit(ADDR, ADDR_HIST_HI))  tmr_next[15:8]      = WR_DATA;
            if (hit(ADDR, ADDR_HIST_CTRL)) begin
                ctrl_next = {3'h0, WR_DATA[4:0]};
            end
            if (hit(ADDR, ADDR_PHOFS0))   phofs_next[7:0]     = WR_DATA;
            if (hit(ADDR, ADDR_PHOFS1))   phofs_next[15:8]    = WR_DATA;
            if (hit(ADDR, ADDR_PHOFS2))   phofs_next[23:16]   = WR_DATA;
            if (hit(ADDR, ADDR_PHOFS3))   phofs_next[29:24]   = WR_DATA[TOP_BYTE_W-1:0];
            if (hit(ADDR, ADDR_STEP_LO))  step_next[7:0]      = WR_DATA;
            if (hit(ADDR, ADDR_STEP_HI))  step_next[15:8]     = WR_DATA;
            if (hit(ADDR, ADDR_SLEW_LO))  slew_next[7:0]      = WR_DATA;
            if (hit(ADDR, ADDR_SLEW_HI))  slew_next[15:8]     = WR_DATA;
            if (hit(ADDR, ADDR_OP_CTRL)) begin
                op_next = WR_DATA[2:0];
            end
        end
    end

    // Read mux; data stands only in the cycle after the strobe, reserved bits read zero.
    always_comb begin
        rd_next = 8'h00;
        if (RD_STB) begin
            case (ADDR)
                ADDR_FREE_TW0:  rd_next = free_tw_reg[7:0];
                ADDR_FREE_TW1:  rd_next = free_tw_reg[15:8];
                ADDR_FREE_TW2:  rd_next = free_tw_reg[23:16];
                ADDR_FREE_TW3:  rd_next = {2'h0, free_tw_reg[29:24]};
                ADDR_HIST_LO:   rd_next = tmr_reg[7:0];
                ADDR_HIST_HI:   rd_next = tmr_reg[15:8];
                ADDR_HIST_CTRL: rd_next = ctrl_reg;
                ADDR_PHOFS0:    rd_next = phofs_reg[7:0];
                ADDR_PHOFS1:    rd_next = phofs_reg[15:8];
                ADDR_PHOFS2:    rd_next = phofs_reg[23:16];
                ADDR_PHOFS3:    rd_next = {2'h0, phofs_reg[29:24]};
                ADDR_STEP_LO:   rd_next = step_reg[7:0];
                ADDR_STEP_HI:   rd_next = step_reg[15:8];
                ADDR_SLEW_LO:   rd_next = slew_reg[7:0];
                ADDR_SLEW_HI:   rd_next = slew_reg[15:8];
                default:        rd_next = 8'h00;
            endcase
        end
    end

    // Millisecond prescaler; a free-running tick keeps timer and slew on a common base.
    always_comb begin
        tick_next = 1'b0;
        pre_next  = pre_reg + 16'h0001;
        if (pre_reg == 16'(MS_CYCLES_P - 1)) begin
            pre_next  = 16'h0000;
            tick_next = 1'b1;
        end
    end

    // Holdover word: averaged history, else the fallback chosen by control bit 4.
    always_comb begin
        last_tw_next = IN_HOLDOVER ? last_tw_reg : LOOP_TW;
        valid_next   = c.hist_valid;
        ofs_next     = c.applied;
        if (c.hist_valid) begin
            hold_next = c.avg_tw;
        end else if (ctrl_reg[FALLBACK_BIT]) begin
            hold_next = last_tw_reg;
        end else begin
            hold_next = free_tw_reg;
        end
    end

    // All bank and output state.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            free_tw_reg <= '0;
            tmr_reg     <= HIST_TMR_RST;
            ctrl_reg    <= 8'h00;
            phofs_reg   <= '0;
            step_reg    <= 16'h0000;
            slew_reg    <= 16'h0000;
            op_reg      <= 3'h0;
            rd_reg      <= 8'h00;
            pre_reg     <= 16'h0000;
            tick_reg    <= 1'b0;
            last_tw_reg <= '0;
            hold_reg    <= '0;
            valid_reg   <= 1'b0;
            ofs_reg     <= '0;
        end else begin
            free_tw_reg <= free_tw_next;
            tmr_reg     <= tmr_next;
            ctrl_reg    <= ctrl_next;
            phofs_reg   <= phofs_next;
            step_reg    <= step_next;
            slew_reg    <= slew_next;
            op_reg      <= op_next;
            rd_reg      <= rd_next;
            pre_reg     <= pre_next;
            tick_reg    <= tick_next;
            last_tw_reg <= last_tw_next;
            hold_reg    <= hold_next;
            valid_reg   <= valid_next;
            ofs_reg     <= ofs_next;
        end
    end

    // Feed the engines; a zero period is left to software to avoid.
    assign c.ms_tick    = tick_reg;
    assign c.period     = tmr_reg;
    assign c.incr       = ctrl_reg[INCR_W-1:0];
    assign c.persist    = ctrl_reg[PERSIST_BIT];
    assign c.ref_switch = REF_SWITCH;
    assign c.holdover   = IN_HOLDOVER;
    assign c.loop_tw    = LOOP_TW;
    assign c.fixed_ofs  = phofs_reg;
    assign c.step       = step_reg;
    assign c.slew       = slew_reg;
    assign c.locked     = LOOP_LOCKED;
    assign c.op_inc     = op_reg[OP_INC_BIT];
    assign c.op_dec     = op_reg[OP_DEC_BIT];
    assign c.op_rst     = op_reg[OP_RST_BIT];

    hph_history u_hist (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .h     (c.hist)
    );

    hph_offset u_offs (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .o     (c.offs)
    );

    assign RD_DATA       = rd_reg;
    assign HOLD_TW       = hold_reg;
    assign HISTORY_VALID = valid_reg;
    assign PHASE_OFFSET  = ofs_reg;

    // Checks on the bank and engines.
    property p_rd_timer;
        @(posedge REF_CLK) disable iff (!RESET_N)
        RD_STB && ADDR == ADDR_HIST_HI |=> RD_DATA == $past(tmr_reg[15:8]);
    endproperty
    a_rd_timer: assert property (p_rd_timer) else $error("Timer high byte misread.");

    property p_rd_gap;
        @(posedge REF_CLK) disable iff (!RESET_N)
        !RD_STB |=> RD_DATA == 8'h00;
    endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("Read data outside its cycle.");

    property p_fb_free;
        @(posedge REF_CLK) disable iff (!RESET_N)
        !c.hist_valid && !ctrl_reg[FALLBACK_BIT] |=> HOLD_TW == $past(free_tw_reg);
    endproperty
    a_fb_free: assert property (p_fb_free) else $error("Free-run fallback not used.");

    property p_fb_last;
        @(posedge REF_CLK) disable iff (!RESET_N)
        !c.hist_valid && ctrl_reg[FALLBACK_BIT] |=> HOLD_TW == $past(last_tw_reg);
    endproperty
    a_fb_last: assert property (p_fb_last) else $error("Last-word fallback not used.");

    property p_clear;
        @(posedge REF_CLK) disable iff (!RESET_N)
        REF_SWITCH && !c.persist |=> !c.hist_valid ##1 !HISTORY_VALID;
    endproperty
    a_clear: assert property (p_clear) else $error("History survived a switch.");

    property p_keep;
        @(posedge REF_CLK) disable iff (!RESET_N)
        REF_SWITCH && c.persist && c.hist_valid |=> c.hist_valid;
    endproperty
    a_keep: assert property (p_keep) else $error("Persistent history lost.");

    property p_step_inc;
        @(posedge REF_CLK) disable iff (!RESET_N)
        c.op_inc && !c.op_dec && !c.op_rst && LOOP_LOCKED
            |=> c.incr_ofs == $past(c.incr_ofs) + PH_W'($past(step_reg));
    endproperty
    a_step_inc: assert property (p_step_inc) else $error("Step increment wrong.");

    property p_step_rst;
        @(posedge REF_CLK) disable iff (!RESET_N)
        WR_STB && ADDR == ADDR_OP_CTRL && WR_DATA[OP_RST_BIT] |=> ##1 c.incr_ofs == '0;
    endproperty
    a_step_rst: assert property (p_step_rst) else $error("Offset reset ignored.");

    property p_no_slew;
        @(posedge REF_CLK) disable iff (!RESET_N)
        slew_reg == 16'h0000 |=> ##1 PHASE_OFFSET == $past(c.target, 2);
    endproperty
    a_no_slew: assert property (p_no_slew) else $error("Offset not applied at once.");

    c_early: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
        c.incr != 3'h0 && $rose(c.hist_valid));
    c_holdover: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
        IN_HOLDOVER && HISTORY_VALID);
    c_switch: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
        REF_SWITCH && c.hist_valid);
    c_slewing: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
        slew_reg != 16'h0000 && c.applied != c.target);
endmodule

// ---- sim/tb_hph_top.sv ----
// Self-checking bench for the loop history and phase offset register block.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_hph_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hph_pkg::*;
    logic                   REF_CLK = 1'b0;
    logic                   RESET_N = 1'b0;
    logic [15:0]            ADDR = 16'h0000;
    logic [7:0]             WR_DATA = 8'h00;
    logic                   WR_STB = 1'b0;
    logic                   RD_STB = 1'b0;
    logic [7:0]             RD_DATA;
    logic [TW_W-1:0]        LOOP_TW = '0;
    logic                   LOOP_LOCKED = 1'b0;
    logic                   REF_SWITCH = 1'b0;
    logic                   IN_HOLDOVER = 1'b0;
    logic [TW_W-1:0]        HOLD_TW;
    logic                   HISTORY_VALID;
    logic signed [PH_W-1:0] PHASE_OFFSET;
    logic                   rd_d = 1'b0;
    logic [7:0]             rd_q[$];
    logic [7:0]             exp_b;
    logic [31:0]            r;
    logic [TW_W-1:0]        tw;
    logic [TW_W-1:0]        fr;
    logic signed [PH_W-1:0] ph;
    logic signed [PH_W-1:0] inc;
    logic [15:0]            step;
    logic [15:0]            zero_a[15] = '{16'h040D, 16'h040E, 16'h040F, 16'h0410, 16'h0411,
        16'h0412, 16'h0413, 16'h0400, 16'h0401, 16'h0402, 16'h0403, 16'h0414, 16'h0415,
        16'h0A24, 16'h0420};
    logic [15:0]            mask_a[6] = '{16'h040D, 16'h0411, 16'h0403, 16'h0413, 16'h0A24,
        16'h0420};
    logic [7:0]             mask_m[6] = '{8'h1F, 8'h3F, 8'h3F, 8'hFF, 8'h00, 8'h00};
    logic [2:0]             cmds[7] = '{3'd0, 3'd1, 3'd1, 3'd2, 3'd3, 3'd4, 3'd1};
    int                     fails = 0;
    int                     n_tests = 0;
    integer                 seed = 32'h9ce857bf;

    // A short millisecond keeps the 8 ms history period within 32 cycles.
    always #20 REF_CLK = ~REF_CLK;
    hph_top #(.MS_CYCLES_P(4)) i_dut (
        .REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .LOOP_TW(LOOP_TW),
        .LOOP_LOCKED(LOOP_LOCKED), .REF_SWITCH(REF_SWITCH), .IN_HOLDOVER(IN_HOLDOVER),
        .HOLD_TW(HOLD_TW), .HISTORY_VALID(HISTORY_VALID), .PHASE_OFFSET(PHASE_OFFSET));

    // Bus cycles: one-cycle strobes launched right after a rising edge.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        ADDR    <= a;
        WR_DATA <= d;
        WR_STB  <= 1'b1;
        @(posedge REF_CLK);
        WR_STB  <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge REF_CLK);
        ADDR   <= a;
        RD_STB <= 1'b1;
        @(posedge REF_CLK);
        RD_STB <= 1'b0;
    endtask
    task automatic wr_n(input logic [15:0] a, input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            wr(a + 16'(i), v[8*i +: 8]);
        end
    endtask
    task automatic sw_ref();
        @(posedge REF_CLK);
        REF_SWITCH <= 1'b1;
        @(posedge REF_CLK);
        REF_SWITCH <= 1'b0;
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe, so it is checked at that falling edge.
    always @(posedge REF_CLK) rd_d <= RD_STB;
    always @(negedge REF_CLK) begin
        if (rd_d) begin
            exp_b = rd_q.pop_front();
            `CHK("RD_DATA", exp_b, RD_DATA)
        end
    end

    // Main sequence: reset values, access masks, fallback, history and phase offset steps.
    initial begin
        r = $random(seed);
        tw = r[TW_W-1:0];
        r = $random(seed);
        fr = r[TW_W-1:0];
        LOOP_TW <= tw;
        repeat (4) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        rd(ADDR_HIST_LO, 8'h0A);
        rd(ADDR_HIST_HI, 8'h00);
        // A long period keeps history from forming while fallback is examined.
        wr(ADDR_HIST_HI, 8'h01);
        foreach (zero_a[i]) rd(zero_a[i], 8'h00);
        `CHK("HOLD_TW", 30'h0, HOLD_TW)
        foreach (mask_a[i]) begin
            r = $random(seed);
            wr(mask_a[i], r[7:0]);
            rd(mask_a[i], r[7:0] & mask_m[i]);
        end
        wr(ADDR_HIST_CTRL, 8'h00);
        wr_n(ADDR_FREE_TW0, {2'b11, fr}, 4);
        repeat (3) @(posedge REF_CLK);
        `CHK("HOLD_TW", fr, HOLD_TW)
        wr(ADDR_HIST_CTRL, 8'h10);
        repeat (3) @(posedge REF_CLK);
        `CHK("HOLD_TW", tw, HOLD_TW)
        `CHK("HISTORY_VALID", 1'b0, HISTORY_VALID)
        // Early update at one eighth of an 8 ms period, then none without the early mode.
        wr(ADDR_HIST_CTRL, 8'h03);
        wr_n(ADDR_HIST_LO, 32'h8, 2);
        sw_ref();
        repeat (10) @(posedge REF_CLK);
        `CHK("HISTORY_VALID", 1'b1, HISTORY_VALID)
        `CHK("HOLD_TW", tw, HOLD_TW)
        wr(ADDR_HIST_CTRL, 8'h00);
        sw_ref();
        repeat (3) @(posedge REF_CLK);
        `CHK("HISTORY_VALID", 1'b0, HISTORY_VALID)
        repeat (21) @(posedge REF_CLK);
        `CHK("HISTORY_VALID", 1'b0, HISTORY_VALID)
        repeat (16) @(posedge REF_CLK);
        `CHK("HISTORY_VALID", 1'b1, HISTORY_VALID)
        wr(ADDR_HIST_CTRL, 8'h08);
        sw_ref();
        repeat (3) @(posedge REF_CLK);
        `CHK("HISTORY_VALID", 1'b1, HISTORY_VALID)
        IN_HOLDOVER <= 1'b1;
        LOOP_TW     <= ~tw;
        repeat (40) @(posedge REF_CLK);
        `CHK("HOLD_TW", tw, HOLD_TW)
        // Negative fixed offset, then steps; the last increment arrives while unlocked.
        r = $random(seed);
        ph = {1'b1, r[PH_W-2:0]};
        wr_n(ADDR_PHOFS0, {2'b10, ph}, 4);
        r = $random(seed);
        step = r[15:0];
        wr_n(ADDR_STEP_LO, {16'h0, step}, 2);
        rd(ADDR_STEP_HI, step[15:8]);
        inc = '0;
        for (int i = 0; i < 7; i++) begin
            LOOP_LOCKED <= (i < 6);
            if (cmds[i] != 3'd0) wr(ADDR_OP_CTRL, {5'b0, cmds[i]});
            if (i < 6 && cmds[i] == 3'd1) inc = inc + PH_W'(step);
            if (i < 6 && cmds[i] == 3'd2) inc = inc - PH_W'(step);
            if (cmds[i][2]) inc = '0;
            repeat (6) @(posedge REF_CLK);
            `CHK("PHASE_OFFSET", ph + inc, PHASE_OFFSET)
        end
        // Code 7 on a 520 ms period must update at 2 ms, long before its 4 ms point.
        IN_HOLDOVER <= 1'b0;
        wr(ADDR_HIST_CTRL, 8'h07);
        wr(ADDR_HIST_HI, 8'h02);
        sw_ref();
        repeat (11) @(posedge REF_CLK);
        `CHK("HISTORY_VALID", 1'b1, HISTORY_VALID)
        complete_run();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (3000) @(posedge REF_CLK);
        fails++;
        complete_run();
    end
endmodule
